// ===== inc/swt_pkg.sv
// Constants, field layout and types shared by the sleep wake-up timer
package swt_pkg;

    // Register indexes; the APB byte address is four times the index
    localparam logic [7:0] SWT_IDX_IRQ = 8'ha1;
    localparam logic [7:0] SWT_IDX_CTRL = 8'ha2;
    localparam logic [7:0] SWT_IDX_EVT_LO = 8'ha3;
    localparam logic [7:0] SWT_IDX_EVT_HI = 8'ha4;
    localparam logic [7:0] SWT_IDX_VIEW_LO = 8'ha5;
    localparam logic [7:0] SWT_IDX_VIEW_HI = 8'ha6;
    localparam logic [7:0] SWT_IDX_AUX = 8'ha7;
    localparam int unsigned SWT_ADDR_W = 12;

    // sleep_control fields
    localparam int unsigned SWT_CTRL_RES_LSB = 0;
    localparam int unsigned SWT_CTRL_RST_BIT = 2;
    localparam int unsigned SWT_CTRL_RSV_LSB = 4;
    localparam logic [2:0] SWT_CTRL_RSV_RST = 3'h7;
    localparam logic [1:0] SWT_RES_RST = 2'h0;

    // sleep_irq_register fields
    localparam int unsigned SWT_IRQ_FLAG_BIT = 0;
    localparam int unsigned SWT_IRQ_RSV1_BIT = 1;
    localparam int unsigned SWT_IRQ_MASK_BIT = 4;
    localparam int unsigned SWT_IRQ_RSV5_BIT = 5;

    // Auxiliary register fields
    localparam int unsigned SWT_AUX_CPU_FLAG_BIT = 0;
    localparam int unsigned SWT_AUX_CPU_EN_BIT = 1;
    localparam int unsigned SWT_AUX_SLEEP_LSB = 2;
    localparam int unsigned SWT_AUX_PWR_LSB = 4;
    localparam int unsigned SWT_AUX_SRC_BIT = 6;

    // Compare value and counter
    localparam logic [7:0] SWT_EVT_LO_RST = 8'h6b;
    localparam logic [7:0] SWT_EVT_HI_RST = 8'h87;
    localparam int unsigned SWT_CNT_W = 31;
    localparam logic [30:0] SWT_CNT_RESET_VAL = 31'h0000004;

    // Slow clock timing
    localparam int unsigned SWT_CLK_HZ = 50_000_000;
    localparam int unsigned SWT_XTAL_HZ = 32_768;
    localparam int unsigned SWT_DIV_W = 11;
    localparam logic [10:0] SWT_RC_DIV_RST = 11'(SWT_CLK_HZ / SWT_XTAL_HZ);

    typedef enum logic [1:0] {
        SWT_PM_ACTIVE = 2'h0,
        SWT_PM_LIGHT0 = 2'h1,
        SWT_PM_LIGHT1 = 2'h2,
        SWT_PM_LIGHT2 = 2'h3
    } swt_pm_e;

endpackage

// ===== logic/swt_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module swt_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } swt_sync_s;

    swt_sync_s st_ff;
    swt_sync_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        for (int i = 0; i < int'(W); i++) begin
            nxt_st.meta[i] = din[i];
            nxt_st.sync[i] = st_ff.meta[i];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dout = st_ff.sync;
endmodule // swt_sync

// ===== logic/swt_slow_tick.sv
// Slow clock tick from crystal pin edges or the calibrated RC divider
`timescale 1ns/1ps
module swt_slow_tick
    import swt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Sources
    input wire logic xtal_level,
    input wire logic src_xtal,
    // Calibration
    input wire logic [swt_pkg::SWT_DIV_W-1:0] cal_value,
    input wire logic cal_load,
    // Tick
    output logic tick
);
    import swt_pkg::*;

    typedef struct packed {
        logic prev;
        logic [SWT_DIV_W-1:0] rc_cnt;
        logic [SWT_DIV_W-1:0] rc_div;
        logic tick;
    } swt_tick_s;

    swt_tick_s st_ff;
    swt_tick_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev = xtal_level;
        nxt_st.tick = 1'b0;
        // Latest valid calibration only; otherwise held
        if (cal_load && cal_value != '0) begin
            nxt_st.rc_div = cal_value;
        end
        if (st_ff.rc_cnt >= st_ff.rc_div - 11'h001) begin
            nxt_st.rc_cnt = '0;
        end else begin
            nxt_st.rc_cnt = st_ff.rc_cnt + 11'h001;
        end
        if (src_xtal) begin
            nxt_st.tick = xtal_level && !st_ff.prev;
        end else begin
            nxt_st.tick = (st_ff.rc_cnt >= st_ff.rc_div - 11'h001);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff.prev <= 1'b0;
            st_ff.rc_cnt <= '0;
            st_ff.rc_div <= SWT_RC_DIV_RST;
            st_ff.tick <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick = st_ff.tick;
endmodule // swt_slow_tick

// ===== logic/swt_top.sv
// Sleep wake-up timer with APB register access
//
// What this block does
// - Software polls the low view byte; its rate follows the resolution.
// - Writing one to the reset bit loads counter with 4 on the next slow tick; reads zero.
// - Resolution picks counter bits 15:0, 20:5, 25:10 or 30:15.
// - Changing resolution never touches the counter itself.
// - Selected 16-bit window reads as two read-only bytes, reset zero.
// - Compare value is two read/write bytes, reset 0x87 and 0x6b.
// - Event sets the pending flag in the interrupt register.
// - With mask set, the event also sets the CPU-side flag.
// - CPU flag with enable set gives an interrupt request.
// - Interrupt request is blocked while sleep mode is not 00.
// - RC divider recalibrates only with crystal on and active or PM0.
// - Event in any of the three light modes returns to active.
// - Counter is 31 bits, clocked by crystal or RC source.
// - Mask at bit 4, pending flag at bit 0, both reset zero.
`timescale 1ns/1ps
module swt_top
    import swt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [swt_pkg::SWT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Slow clock pins
    input wire logic xtal_32k,
    input wire logic xosc_running,
    // Calibration result from the RC calibrator
    input wire logic [swt_pkg::SWT_DIV_W-1:0] cal_value,
    input wire logic cal_valid,
    // System outputs
    output logic irq_req,
    output logic wake,
    output logic [1:0] power_mode
);
    import swt_pkg::*;

    typedef struct packed {
        logic [SWT_CNT_W-1:0] cnt;
        logic rst_pend;
        logic [1:0] res;
        logic [2:0] ctrl_rsv;
        logic [7:0] evt_lo;
        logic [7:0] evt_hi;
        logic evt_flag;
        logic evt_mask;
        logic irq_rsv1;
        logic irq_rsv5;
        logic cpu_flag;
        logic cpu_en;
        logic [1:0] sleep_mode;
        swt_pm_e pm;
        logic src_xtal;
        logic irq_req;
        logic wake;
        logic [31:0] rdata;
    } swt_top_s;

    swt_top_s st_ff;
    swt_top_s nxt_st;

    logic [1:0] pin_sync;
    logic tick;
    logic cal_load;

    // Counter window selected by resolution
    function automatic logic [15:0] win_sel(input logic [30:0] c,
                                            input logic [1:0] r);
        logic [15:0] w;
        w = c[15:0];
        case (r)
            2'h0: w = c[15:0];
            2'h1: w = c[20:5];
            2'h2: w = c[25:10];
            2'h3: w = c[30:15];
            default: w = c[15:0];
        endcase
        return w;
    endfunction

    // Register index from byte address
    function automatic logic [7:0] reg_idx(
        input logic [SWT_ADDR_W-1:0] a);
        return a[9:2];
    endfunction

    function automatic logic is_mapped(input logic [SWT_ADDR_W-1:0] a);
        logic [7:0] i;
        i = reg_idx(a);
        return (a[1:0] == 2'h0) && (a[SWT_ADDR_W-1:10] == '0) &&
            (i >= SWT_IDX_IRQ) && (i <= SWT_IDX_AUX);
    endfunction

    swt_sync #(
        .W(2)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .din({xosc_running, xtal_32k}),
        .dout(pin_sync)
    );

    // Calibration only with crystal running, active or lightest mode
    assign cal_load = cal_valid && pin_sync[1] &&
        (st_ff.pm == SWT_PM_ACTIVE || st_ff.pm == SWT_PM_LIGHT0);

    swt_slow_tick u_tick (
        .clk(clk),
        .resetn(resetn),
        .xtal_level(pin_sync[0]),
        .src_xtal(st_ff.src_xtal),
        .cal_value(cal_value),
        .cal_load(cal_load),
        .tick(tick)
    );

    logic setup;
    logic wr_acc;
    logic [7:0] idx;
    logic [7:0] wb;
    logic [SWT_CNT_W-1:0] cnt_new;
    logic [15:0] win_old;
    logic [15:0] win_new;
    logic event_hit;

    assign setup = psel && !penable;
    assign wr_acc = psel && penable && pwrite && is_mapped(paddr);
    assign idx = reg_idx(paddr);
    assign wb = pwdata[7:0];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.wake = 1'b0;
        cnt_new = st_ff.cnt;
        event_hit = 1'b0;

        // Counter advance on slow tick
        if (tick) begin
            if (st_ff.rst_pend) begin
                cnt_new = SWT_CNT_RESET_VAL;
            end else begin
                cnt_new = st_ff.cnt + 31'h0000001;
            end
        end
        win_old = win_sel(st_ff.cnt, st_ff.res);
        win_new = win_sel(cnt_new, st_ff.res);
        if (tick && win_new != win_old &&
            win_new == {st_ff.evt_hi, st_ff.evt_lo}) begin
            event_hit = 1'b1;
        end
        nxt_st.cnt = cnt_new;
        if (tick) begin
            nxt_st.rst_pend = 1'b0;
        end

        // Register writes
        if (wr_acc) begin
            case (idx)
                SWT_IDX_IRQ: begin
                    nxt_st.evt_mask = wb[SWT_IRQ_MASK_BIT];
                    nxt_st.irq_rsv5 = wb[SWT_IRQ_RSV5_BIT];
                    if (!wb[SWT_IRQ_RSV1_BIT]) begin
                        nxt_st.irq_rsv1 = 1'b0;
                    end
                    if (!wb[SWT_IRQ_FLAG_BIT]) begin
                        nxt_st.evt_flag = 1'b0;
                    end
                end
                SWT_IDX_CTRL: begin
                    // Resolution only changes the view
                    nxt_st.res = wb[SWT_CTRL_RES_LSB +: 2];
                    nxt_st.ctrl_rsv = wb[SWT_CTRL_RSV_LSB +: 3];
                    if (wb[SWT_CTRL_RST_BIT]) begin
                        nxt_st.rst_pend = 1'b1;
                    end
                end
                SWT_IDX_EVT_LO: nxt_st.evt_lo = wb;
                SWT_IDX_EVT_HI: nxt_st.evt_hi = wb;
                SWT_IDX_AUX: begin
                    if (!wb[SWT_AUX_CPU_FLAG_BIT]) begin
                        nxt_st.cpu_flag = 1'b0;
                    end
                    nxt_st.cpu_en = wb[SWT_AUX_CPU_EN_BIT];
                    nxt_st.sleep_mode = wb[SWT_AUX_SLEEP_LSB +: 2];
                    nxt_st.pm = swt_pm_e'(wb[SWT_AUX_PWR_LSB +: 2]);
                    nxt_st.src_xtal = wb[SWT_AUX_SRC_BIT];
                end
                default: begin
                end
            endcase
        end

        // Event effects; set wins over a same-cycle clear
        if (event_hit) begin
            nxt_st.evt_flag = 1'b1;
            if (st_ff.evt_mask) begin
                nxt_st.cpu_flag = 1'b1;
            end
            if (st_ff.pm != SWT_PM_ACTIVE) begin
                nxt_st.pm = SWT_PM_ACTIVE;
                nxt_st.wake = 1'b1;
            end
        end

        nxt_st.irq_req = nxt_st.cpu_flag && nxt_st.cpu_en &&
            (nxt_st.sleep_mode == 2'h0);

        // Read data captured in setup phase
        if (setup) begin
            nxt_st.rdata = '0;
            if (is_mapped(paddr)) begin
                case (idx)
                    SWT_IDX_IRQ: begin
                        nxt_st.rdata[SWT_IRQ_FLAG_BIT] = st_ff.evt_flag;
                        nxt_st.rdata[SWT_IRQ_RSV1_BIT] = st_ff.irq_rsv1;
                        nxt_st.rdata[SWT_IRQ_MASK_BIT] = st_ff.evt_mask;
                        nxt_st.rdata[SWT_IRQ_RSV5_BIT] = st_ff.irq_rsv5;
                    end
                    SWT_IDX_CTRL: begin
                        nxt_st.rdata[SWT_CTRL_RES_LSB +: 2] = st_ff.res;
                        nxt_st.rdata[SWT_CTRL_RSV_LSB +: 3] = st_ff.ctrl_rsv;
                    end
                    SWT_IDX_EVT_LO: nxt_st.rdata[7:0] = st_ff.evt_lo;
                    SWT_IDX_EVT_HI: nxt_st.rdata[7:0] = st_ff.evt_hi;
                    SWT_IDX_VIEW_LO: nxt_st.rdata[7:0] = win_old[7:0];
                    SWT_IDX_VIEW_HI: nxt_st.rdata[7:0] = win_old[15:8];
                    SWT_IDX_AUX: begin
                        nxt_st.rdata[SWT_AUX_CPU_FLAG_BIT] = st_ff.cpu_flag;
                        nxt_st.rdata[SWT_AUX_CPU_EN_BIT] = st_ff.cpu_en;
                        nxt_st.rdata[SWT_AUX_SLEEP_LSB +: 2] =
                            st_ff.sleep_mode;
                        nxt_st.rdata[SWT_AUX_PWR_LSB +: 2] = st_ff.pm;
                        nxt_st.rdata[SWT_AUX_SRC_BIT] = st_ff.src_xtal;
                    end
                    default: nxt_st.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            st_ff.cnt <= '0;
            st_ff.rst_pend <= 1'b0;
            st_ff.res <= SWT_RES_RST;
            st_ff.ctrl_rsv <= SWT_CTRL_RSV_RST;
            st_ff.evt_lo <= SWT_EVT_LO_RST;
            st_ff.evt_hi <= SWT_EVT_HI_RST;
            st_ff.evt_flag <= 1'b0;
            st_ff.evt_mask <= 1'b0;
            st_ff.irq_rsv1 <= 1'b0;
            st_ff.irq_rsv5 <= 1'b0;
            st_ff.cpu_flag <= 1'b0;
            st_ff.cpu_en <= 1'b0;
            st_ff.sleep_mode <= 2'h0;
            st_ff.pm <= SWT_PM_ACTIVE;
            st_ff.src_xtal <= 1'b0;
            st_ff.irq_req <= 1'b0;
            st_ff.wake <= 1'b0;
            st_ff.rdata <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // One wait-free access phase; unmapped addresses report an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !is_mapped(paddr);
    assign prdata = st_ff.rdata;
    assign irq_req = st_ff.irq_req;
    assign wake = st_ff.wake;
    assign power_mode = st_ff.pm;
endmodule // swt_top

// ===== verification/swt_top_asserts.sv
// Concurrent checks on the sleep wake-up timer ports
`timescale 1ns/1ps
module swt_top_asserts
    import swt_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [swt_pkg::SWT_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Slow clock pins and calibration result
    input wire logic xtal_32k,
    input wire logic xosc_running,
    input wire logic [swt_pkg::SWT_DIV_W-1:0] cal_value,
    input wire logic cal_valid,
    // System outputs
    input wire logic irq_req,
    input wire logic wake,
    input wire logic [1:0] power_mode
);
    logic acc;
    logic hit;
    assign acc = psel && penable;
    assign hit = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
        && paddr[9:2] >= SWT_IDX_IRQ && paddr[9:2] <= SWT_IDX_AUX;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_rst_out;
        @(posedge clk) disable iff (1'b0)
            !resetn |=> !irq_req && !wake && power_mode == 2'h0;
    endproperty
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not cleared by reset");
    property p_wake_pulse;
        wake |=> !wake;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake longer than one cycle");
    property p_wake_active;
        wake |-> power_mode == 2'h0 && $past(power_mode) != 2'h0;
    endproperty
    a_wake_active: assert property (p_wake_active)
        else $error("wake without return to active");
    property p_mode_drop;
        $past(power_mode) != 2'h0 && power_mode == 2'h0 |->
            wake || $past(acc && pwrite);
    endproperty
    a_mode_drop: assert property (p_mode_drop)
        else $error("light mode left without wake");
    property p_err_map;
        acc && !hit |-> pslverr && prdata == 32'h0;
    endproperty
    a_err_map: assert property (p_err_map)
        else $error("unmapped access not refused");
    property p_ok_map;
        acc && hit |-> !pslverr;
    endproperty
    a_ok_map: assert property (p_ok_map)
        else $error("mapped access refused");
    property p_err_idle;
        !acc |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle)
        else $error("error outside access phase");
    property p_rd_stable;
        acc |-> prdata[31:8] == 24'h0 ##1 $stable(prdata);
    endproperty
    a_rd_stable: assert property (p_rd_stable)
        else $error("read data moved in access phase");

    c_wake: cover property (wake);
    c_irq: cover property ($rose(irq_req));
    c_err: cover property (acc && pslverr);
endmodule // swt_top_asserts

bind swt_top swt_top_asserts u_chk (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtal_32k(xtal_32k), .xosc_running(xosc_running),
    .cal_value(cal_value), .cal_valid(cal_valid), .irq_req(irq_req),
    .wake(wake), .power_mode(power_mode));

// ===== verification/swt_top_tb_top.sv
// Self-checking bench for the sleep wake-up timer
`timescale 1ns/1ps
module swt_top_tb_top;
    import swt_pkg::*;
    logic clk, resetn, psel, penable, pwrite, xtal_32k, xosc_running, e;
    logic cal_valid, pready, pslverr, irq_req, wake;
    logic [SWT_ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [10:0] cal_value;
    logic [1:0] power_mode;
    int miscompares = 0;
    int num_checks = 0;

    swt_top dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xtal_32k(xtal_32k),
        .xosc_running(xosc_running), .cal_value(cal_value),
        .cal_valid(cal_valid), .irq_req(irq_req), .wake(wake),
        .power_mode(power_mode));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic close_out();
        if (miscompares == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: saw %h not %h", $time, seen, exp);
        end
    endtask

    // One APB transfer; waits for pready under a bound
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            miscompares++;
            close_out();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rd, exp);
    endtask

    // Counter steps over 80 clocks at resolution 00
    task automatic ticks(input logic [31:0] exp);
        logic [31:0] a;
        repeat (40) @(posedge clk);
        apb(1'b0, SWT_IDX_VIEW_LO, 8'h00);
        a = rd;
        repeat (77) @(posedge clk);
        apb(1'b0, SWT_IDX_VIEW_LO, 8'h00);
        check((rd - a) & 32'hff, exp);
    endtask

    // Crystal pin pulses, each rising edge one slow tick
    task automatic slow(input int n);
        repeat (n) begin
            xtal_32k <= 1'b1;
            repeat (6) @(posedge clk);
            xtal_32k <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask

    initial begin
        resetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        xtal_32k = 1'b0;
        xosc_running = 1'b1;
        cal_value = 11'h8;
        cal_valid = 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rdchk(SWT_IDX_CTRL, 32'h70);
        rdchk(SWT_IDX_EVT_LO, 32'h6b);
        rdchk(SWT_IDX_EVT_HI, 32'h87);
        rdchk(SWT_IDX_VIEW_LO, 32'h0);
        rdchk(SWT_IDX_VIEW_HI, 32'h0);
        rdchk(SWT_IDX_IRQ, 32'h0);
        apb(1'b0, 8'h00, 8'h00);
        check({31'h0, e}, 32'h1);
        wr(SWT_IDX_AUX, 8'h42);
        cal_valid <= 1'b1;
        wr(SWT_IDX_CTRL, 8'h04);
        rdchk(SWT_IDX_CTRL, 32'h0);
        slow(1);
        rdchk(SWT_IDX_VIEW_LO, 32'h4);
        wr(SWT_IDX_VIEW_LO, 8'hff);
        rdchk(SWT_IDX_VIEW_LO, 32'h4);
        slow(60);
        for (int r = 0; r < 4; r++) begin
            wr(SWT_IDX_CTRL, 8'(r));
            rdchk(SWT_IDX_VIEW_LO, 32'h40 >> (5 * r));
        end
        wr(SWT_IDX_CTRL, 8'h00);
        rdchk(SWT_IDX_VIEW_LO, 32'h40);
        rdchk(SWT_IDX_VIEW_HI, 32'h0);
        wr(SWT_IDX_EVT_HI, 8'h00);
        wr(SWT_IDX_EVT_LO, 8'h44);
        wr(SWT_IDX_IRQ, 8'h10);
        wr(SWT_IDX_AUX, 8'h52);
        @(negedge clk);
        check({30'h0, power_mode}, 32'h1);
        slow(4);
        check({31'h0, irq_req}, 32'h1);
        check({30'h0, power_mode}, 32'h0);
        rdchk(SWT_IDX_IRQ, 32'h11);
        apb(1'b0, SWT_IDX_AUX, 8'h00);
        check(rd & 32'h1, 32'h1);
        wr(SWT_IDX_IRQ, 8'h10);
        wr(SWT_IDX_AUX, 8'h42);
        @(negedge clk);
        check({31'h0, irq_req}, 32'h0);
        rdchk(SWT_IDX_IRQ, 32'h10);
        wr(SWT_IDX_AUX, 8'h46);
        wr(SWT_IDX_EVT_LO, 8'h48);
        slow(4);
        check({31'h0, irq_req}, 32'h0);
        apb(1'b0, SWT_IDX_AUX, 8'h00);
        check(rd & 32'h1, 32'h1);
        wr(SWT_IDX_IRQ, 8'h00);
        wr(SWT_IDX_AUX, 8'h42);
        wr(SWT_IDX_EVT_LO, 8'h4c);
        slow(4);
        rdchk(SWT_IDX_IRQ, 32'h1);
        apb(1'b0, SWT_IDX_AUX, 8'h00);
        check(rd & 32'h1, 32'h0);
        check({31'h0, irq_req}, 32'h0);
        wr(SWT_IDX_IRQ, 8'h00);
        wr(SWT_IDX_CTRL, 8'h04);
        slow(2);
        rdchk(SWT_IDX_VIEW_LO, 32'h5);
        wr(SWT_IDX_EVT_HI, 8'h00);
        wr(SWT_IDX_EVT_LO, 8'h08);
        slow(3);
        rdchk(SWT_IDX_IRQ, 32'h1);
        wr(SWT_IDX_AUX, 8'h22);
        cal_value <= 11'h10;
        ticks(32'ha);
        wr(SWT_IDX_AUX, 8'h02);
        ticks(32'h5);
        close_out();
    end
endmodule // swt_top_tb_top
